// ### hdl/dual_modulus_prescaler.sv
// Dual-modulus divider: divides clock by 64/65 or 128/129.
// Assumes control inputs are asynchronous pins; output feeds external counters.
`timescale 1ns/1ps
module dual_modulus_prescaler #(
  parameter logic NegEdgeVariant = prescaler_pkg::NEG_EDGE_VARIANT
) (
  // Clock and reset
  input  wire  logic clock,
  input  wire  logic reset_n,
  // Ratio control pins
  input  wire  logic ratio_range_select,
  input  wire  logic modulus_select,
  // Divided output
  output logic       dividedOut
);
  import prescaler_pkg::*;

  // Divider state: place in the period, the ratio it runs and its half mark.
  // The half mark is stored with the ratio so no shifter sits in the count path.
  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] ratio;
    logic [CNT_W-1:0] half;
    logic             outLevel;
  } div_t;

  div_t state_ff;
  div_t nxt_state;

  // Control pins before and after the synchronisers
  logic [PIN_COUNT-1:0] pinsAsync;
  logic [PIN_COUNT-1:0] pinsSync;
  logic                 rangeSync;
  logic                 modSync;

  // Ratio decode
  logic [CNT_W-1:0]     ratioBase;
  logic [CNT_W-1:0]     pickRatio;
  logic [CNT_W-1:0]     pickHalf;

  // Ratio legality of the running period
  logic                 ratioLegal;

  // Period bookkeeping
  logic [CNT_W-1:0]     lastCount;
  logic [CNT_W-1:0]     stepCount;
  logic                 wrapNow;
  logic                 halfNow;

  // Output levels of the chosen variant
  logic                 boundaryLevel;
  logic                 middleLevel;

  assign pinsAsync[PIN_RANGE] = ratio_range_select;
  assign pinsAsync[PIN_MOD]   = modulus_select;

  // One synchroniser per control pin.
  // Open range pin is expected to be pulled low by the pad.
  for (genvar pin = 0; pin < PIN_COUNT; pin++) begin : g_pinSync
    sync_two_ff uSync (
      .clock   (clock),
      .reset_n (reset_n),
      .asyncIn (pinsAsync[pin]),
      .syncOut (pinsSync[pin])
    );
  end

  assign rangeSync = pinsSync[PIN_RANGE];
  assign modSync   = pinsSync[PIN_MOD];

  // Range picks the ratio pair
  always_comb begin
    if (rangeSync) begin
      ratioBase = RATIO_LOW_RANGE;
    end else begin
      ratioBase = RATIO_HIGH_RANGE;
    end
  end

  // Modulus high keeps the lower ratio, low adds one
  always_comb begin
    if (modSync) begin
      pickRatio = ratioBase;
    end else begin
      pickRatio = CNT_W'(ratioBase + RATIO_EXTRA);
    end
  end

  // Half mark rounds down: odd ratios spend one more cycle at the middle level
  assign pickHalf = pickRatio >> 1;

  // Only the four pair members may ever run
  always_comb begin
    if (state_ff.ratio == RATIO_LOW_RANGE) begin
      ratioLegal = 1'b1;
    end else if (state_ff.ratio == CNT_W'(RATIO_LOW_RANGE + RATIO_EXTRA)) begin
      ratioLegal = 1'b1;
    end else if (state_ff.ratio == RATIO_HIGH_RANGE) begin
      ratioLegal = 1'b1;
    end else if (state_ff.ratio == CNT_W'(RATIO_HIGH_RANGE + RATIO_EXTRA)) begin
      ratioLegal = 1'b1;
    end else begin
      ratioLegal = 1'b0;
    end
  end

  // Count arithmetic kept at counter width on purpose
  assign lastCount = CNT_W'(state_ff.ratio - RATIO_EXTRA);
  assign stepCount = CNT_W'(state_ff.count + RATIO_EXTRA);

  // Wrap on the last count; an upset ratio wraps at once and reloads
  always_comb begin
    if (!ratioLegal) begin
      wrapNow = 1'b1;
    end else if (state_ff.count >= lastCount) begin
      wrapNow = 1'b1;
    end else begin
      wrapNow = 1'b0;
    end
  end

  // Middle of the period reached on the next count
  always_comb begin
    if (stepCount == state_ff.half) begin
      halfNow = 1'b1;
    end else begin
      halfNow = 1'b0;
    end
  end

  // Positive variant rises at the boundary, negative variant falls there
  always_comb begin
    if (NegEdgeVariant) begin
      boundaryLevel = 1'b0;
      middleLevel   = 1'b1;
    end else begin
      boundaryLevel = 1'b1;
      middleLevel   = 1'b0;
    end
  end

  // Next state of the divider
  always_comb begin
    nxt_state = state_ff;
    if (wrapNow) begin
      // Ratio latched once per period so a period never mixes moduli
      nxt_state.count    = CNT_RESET;
      nxt_state.ratio    = pickRatio;
      nxt_state.half     = pickHalf;
      nxt_state.outLevel = boundaryLevel;
    end else begin
      nxt_state.count = stepCount;
      if (halfNow) begin
        nxt_state.outLevel = middleLevel;
      end
    end
  end

  // State register; reset leaves the output at its middle level
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff.count    <= CNT_RESET;
      state_ff.ratio    <= RATIO_HIGH_RANGE;
      state_ff.half     <= RATIO_HIGH_RANGE >> 1;
      state_ff.outLevel <= NegEdgeVariant;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Straight from the flop, so the counters see no decode glitches
  assign dividedOut = state_ff.outLevel;

  // Timing of one period, ratio N, half mark H = N >> 1:
  //   count 0      boundary level, edge just made
  //   count H      middle level
  //   count N - 1  last count, ratio reloaded from the pins
  //   count 0      boundary level again, next edge
  // A change of either pin needs two clocks through the flops,
  // then waits for the end of the running period.
  // The first period after reset always runs the reset ratio.
endmodule

// ### hdl/prescaler_pkg.sv
// Constants for the dual-modulus prescaler.
// Assumes a single clock domain; control inputs arrive from outside it.
// How it works
// - Range select high picks the 64/65 pair, low or open picks the 128/129 pair.
// - Range select is fixed first; modulus select high divides by the lower ratio, low by the higher.
// - The positive-edge variant marks each count boundary with a rising output edge.
// - The negative-edge variant marks each count boundary with a falling output edge.
package prescaler_pkg;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] RATIO_LOW_RANGE  = 8'h40;
  localparam logic [CNT_W-1:0] RATIO_HIGH_RANGE = 8'h80;
  localparam logic [CNT_W-1:0] RATIO_EXTRA      = 8'h01;
  localparam logic [CNT_W-1:0] CNT_RESET        = 8'h00;
  localparam logic             NEG_EDGE_VARIANT = 1'b0;
  // Bit positions of the control pins inside the synchroniser bank
  localparam int               PIN_RANGE        = 0;
  localparam int               PIN_MOD          = 1;
  localparam int               PIN_COUNT        = 2;
endpackage

// ### hdl/sync_two_ff.sv
// Two-flop synchroniser for one level input.
// Assumes the input is quasi-static relative to clock.
`timescale 1ns/1ps
module sync_two_ff (
  // Clock and reset
  input  wire  logic clock,
  input  wire  logic reset_n,
  // Level in and out
  input  wire  logic asyncIn,
  output logic       syncOut
);
  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_t;
  sync_t state_ff;
  sync_t nxt_state;

  always_comb begin
    nxt_state.stage1 = asyncIn;
    nxt_state.stage2 = state_ff.stage1;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign syncOut = state_ff.stage2;
endmodule

// ### sim/prescaler_monitor.sv
// Checker: divided output periods and edge shape.
// Assumes a bind to the prescaler top.
`timescale 1ns/1ps
module prescaler_monitor #(parameter logic NegEdgeVariant = 1'b0) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ratio_range_select,
  input wire logic modulus_select,
  input wire logic dividedOut
);
  logic [7:0] gap_ff;
  logic       prev_ff, seen_ff;
  wire        lvl = dividedOut ^ NegEdgeVariant;
  wire        bnd = lvl & ~prev_ff;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n) {gap_ff, prev_ff, seen_ff} <= '0;
    else {gap_ff, prev_ff, seen_ff} <= {bnd ? 8'h01 : gap_ff + 8'h01, lvl, seen_ff | bnd};
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_boundary;
    bnd;
  endsequence
  sequence s_mid_turn;
    seen_ff && $fell(lvl);
  endsequence
  a_period_set: assert property (seen_ff && bnd |-> gap_ff inside {8'h40, 8'h41, 8'h80, 8'h81})
    else $error("period off");
  a_half_turn: assert property (s_mid_turn |-> gap_ff inside {[31:33], [63:65]})
    else $error("half off");
  a_edge_hold: assert property (s_boundary |=> lvl [*8]) else $error("edge level lost");
  a_mid_hold: assert property (s_mid_turn |=> !lvl [*8]) else $error("middle level lost");
  a_gap_bound: assert property (seen_ff |-> gap_ff <= 8'h81) else $error("boundary overdue");
endmodule
bind dual_modulus_prescaler prescaler_monitor #(.NegEdgeVariant(NegEdgeVariant)) i_mon (
  .clock(clock), .reset_n(reset_n), .ratio_range_select(ratio_range_select),
  .modulus_select(modulus_select), .dividedOut(dividedOut));

// ### sim/synth_counter_model.sv
// Counter model: clocks between rising output edges, or between falling ones with FallEdge set.
`timescale 1ns/1ps
module synth_counter_model #(parameter logic FallEdge = 1'b0) (
  input  wire logic       clock,
  input  wire logic       dividedOut,
  output logic      [7:0] period
);
  logic [7:0] run = 8'h00;
  logic       last = 1'b0;
  wire        edgeSeen = FallEdge ? (!dividedOut && last) : (dividedOut && !last);
  always @(posedge clock) begin
    last <= dividedOut;
    run <= edgeSeen ? 8'h01 : run + 8'h01;
    if (edgeSeen) period <= run;
  end
endmodule

// ### sim/tb_dual_modulus_prescaler.sv
// Bench: each divide ratio in turn.
`timescale 1ns/1ps
module tb_dual_modulus_prescaler;
  import prescaler_pkg::*;
  logic       clock = 1'b0, reset_n = 1'b0, rangeSel = 1'b0, modSel = 1'b1, dividedOut;
  logic [7:0] period, periodNeg;
  logic       dividedOutNeg;
  int         miscompares = 0, compares = 0;
  always #5 clock = ~clock;
  dual_modulus_prescaler i_dut (.clock(clock), .reset_n(reset_n),
    .ratio_range_select(rangeSel), .modulus_select(modSel), .dividedOut(dividedOut));
  synth_counter_model i_synth (.clock(clock), .dividedOut(dividedOut), .period(period));
  dual_modulus_prescaler #(.NegEdgeVariant(1'b1)) i_dutNeg (.clock(clock), .reset_n(reset_n),
    .ratio_range_select(rangeSel), .modulus_select(modSel), .dividedOut(dividedOutNeg));
  synth_counter_model #(.FallEdge(1'b1)) i_synthNeg (.clock(clock), .dividedOut(dividedOutNeg),
    .period(periodNeg));
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check_ratio(input logic rs, input logic ms, input logic [7:0] exp);
    @(posedge clock);
    {rangeSel, modSel} <= {rs, ms};
    for (int n = 0; n < 600 && (period !== exp || periodNeg !== exp); n++) @(negedge clock);
    compares += 2;
    $display("ratio %h done", exp);
    if (period !== exp) begin
      miscompares++;
      $display("BAD %0t %h %h", $time, period, exp);
    end
    if (periodNeg !== exp) begin
      miscompares++;
      $display("BAD %0t %h %h", $time, periodNeg, exp);
    end
    if (miscompares != 0) end_of_test();
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    check_ratio(1'b0, 1'b1, RATIO_HIGH_RANGE);
    check_ratio(1'b0, 1'b0, RATIO_HIGH_RANGE + RATIO_EXTRA);
    check_ratio(1'b1, 1'b0, RATIO_LOW_RANGE + RATIO_EXTRA);
    check_ratio(1'b1, 1'b1, RATIO_LOW_RANGE);
    end_of_test();
  end
endmodule
